/* hw/ocl_pkg.sv */
// Constants for the oscillator and pin-lock configuration decoder
package ocl_pkg;
    localparam int CFG_W = 24;
    localparam logic [CFG_W-1:0] CFG_ERASED = 24'hFFFFFF;
    // Field positions inside the configuration word
    localparam int CS_FIELD_LSB = 6;
    localparam int OUT_FN_BIT = 5;
    localparam int ONE_WAY_BIT = 4;
    localparam int RSVD_HI_BIT = 3;
    localparam int RSVD_LO_BIT = 2;
    localparam int MODE_LSB = 0;
    // Clock-switch / monitor field codes
    localparam logic [1:0] CS_SW_FSM = 2'h0;
    localparam logic [1:0] CS_SW_ONLY = 2'h1;
    // Primary oscillator mode codes
    typedef enum logic [1:0] {
        OCL_EXT_CLK = 2'h0,
        OCL_XTAL_STD = 2'h1,
        OCL_XTAL_HS = 2'h2,
        OCL_OSC_OFF = 2'h3
    } ocl_mode_t;
    // APB byte addresses
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_UNLOCK = 8'h08;
    localparam logic [7:0] ADDR_LOCK = 8'h0C;
    localparam logic [7:0] ADDR_MAP_BASE = 8'h10;
    // Unlock key pair, written back to back to the unlock register
    localparam logic [7:0] UNLOCK_KEY1 = 8'h46;
    localparam logic [7:0] UNLOCK_KEY2 = 8'h57;
    localparam logic [7:0] MAP_RESET = 8'h00;
endpackage

/* hw/ocl_config_decode.sv */
// Configuration word decoder with pin-select lock and mapping registers on APB
`timescale 1ns/1ps

module ocl_config_decode #(
    parameter int MAP_REGS = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [ocl_pkg::CFG_W-1:0] config_word_two,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic clkSwitchEn,
    output logic failSafeMonEn,
    output logic primaryOscEn,
    output logic oscModeHs,
    output logic oscModeXt,
    output logic oscModeEc,
    output logic crystalDriverOwnsPin,
    output logic oscOutPinOut,
    output logic oscOutPinOe,
    output logic pin_select_lock,
    output logic [MAP_REGS*8-1:0] ppsMap
);
    import ocl_pkg::*;

    logic rstSync1;
    logic rstSync2;
    logic captured;
    logic [CFG_W-1:0] cfgWord;
    logic keyHalf;
    logic unlockArmed;
    logic clkDiv;
    logic [7:0] mapReg [MAP_REGS];

    // Reset released through two flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    // Word is caught once after reset; erased value stands until then, which decodes to oscillator off with the clock output pin enabled
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            captured <= 1'b0;
            cfgWord <= CFG_ERASED;
        end else if (!captured) begin
            captured <= 1'b1;
            cfgWord <= config_word_two;
        end
    end

    // Field decode
    wire [1:0] csField = cfgWord[CS_FIELD_LSB +: 2];
    wire outFnBit = cfgWord[OUT_FN_BIT];
    wire pin_lock_one_way = cfgWord[ONE_WAY_BIT];
    wire rsvdOk = cfgWord[RSVD_HI_BIT] & cfgWord[RSVD_LO_BIT];
    wire [1:0] primary_osc_mode = cfgWord[MODE_LSB +: 2];
    wire modeOff = primary_osc_mode == OCL_OSC_OFF;
    wire modeXtalAny = (primary_osc_mode == OCL_XTAL_HS) || (primary_osc_mode == OCL_XTAL_STD);
    wire clkOutSel = !modeXtalAny && outFnBit;

    // Decoded outputs are flops held at zero until the word is caught, so the erased
    // value never drives the output pin for a cycle while a crystal may sit on it
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            clkSwitchEn <= 1'b0;
            failSafeMonEn <= 1'b0;
            primaryOscEn <= 1'b0;
            oscModeHs <= 1'b0;
            oscModeXt <= 1'b0;
            oscModeEc <= 1'b0;
            crystalDriverOwnsPin <= 1'b0;
            oscOutPinOe <= 1'b0;
        end else if (captured) begin
            clkSwitchEn <= (csField == CS_SW_FSM) || (csField == CS_SW_ONLY);
            failSafeMonEn <= csField == CS_SW_FSM;
            primaryOscEn <= !modeOff;
            oscModeHs <= primary_osc_mode == OCL_XTAL_HS;
            oscModeXt <= primary_osc_mode == OCL_XTAL_STD;
            oscModeEc <= primary_osc_mode == OCL_EXT_CLK;
            crystalDriverOwnsPin <= modeXtalAny;
            oscOutPinOe <= clkOutSel;
        end
    end

    // Core clock divided by two on the output pin
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            clkDiv <= 1'b0;
        end else begin
            clkDiv <= !clkDiv;
        end
    end
    assign oscOutPinOut = clkDiv & oscOutPinOe;

    // APB decode; answers in the access cycle with no wait state
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire wrStrobe = access && pwrite;
    wire isMap = (paddr >= ADDR_MAP_BASE) && (paddr < ADDR_MAP_BASE + 8'(MAP_REGS * 4));
    wire [7:0] mapOff = paddr - ADDR_MAP_BASE;
    wire [5:0] mapIdx = mapOff[7:2];
    wire aligned = paddr[1:0] == 2'h0;
    wire isKnown = aligned && ((paddr == ADDR_CFG) || (paddr == ADDR_STATUS)
        || (paddr == ADDR_UNLOCK) || (paddr == ADDR_LOCK) || isMap);
    wire wrUnlock = wrStrobe && paddr == ADDR_UNLOCK;
    wire wrLock = wrStrobe && paddr == ADDR_LOCK;
    wire lockReq = pwdata[0];
    wire mapWrite = wrStrobe && isMap && aligned && !pin_select_lock;
    assign pready = 1'b1;
    assign pslverr = access && !isKnown;

    wire [31:0] statusWord = {22'h0, rsvdOk, unlockArmed, pin_lock_one_way, pin_select_lock,
        oscOutPinOe, crystalDriverOwnsPin, primaryOscEn, failSafeMonEn, clkSwitchEn, captured};
    wire [31:0] mapRead = {24'h0, mapReg[mapIdx[$clog2(MAP_REGS)-1:0]]};
    wire [31:0] next_prdata = !isKnown ? 32'h0 :
        (paddr == ADDR_CFG) ? {8'h0, cfgWord} :
        (paddr == ADDR_STATUS) ? statusWord :
        (paddr == ADDR_UNLOCK) ? {31'h0, unlockArmed} :
        (paddr == ADDR_LOCK) ? {31'h0, pin_select_lock} : mapRead;

    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            prdata <= 32'h0;
        end else if (setup && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // Unlock: key1 then key2 as consecutive writes; any lock write consumes it
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            keyHalf <= 1'b0;
            unlockArmed <= 1'b0;
        end else if (wrUnlock) begin
            keyHalf <= pwdata[7:0] == UNLOCK_KEY1;
            unlockArmed <= keyHalf && pwdata[7:0] == UNLOCK_KEY2;
        end else if (wrStrobe) begin
            keyHalf <= 1'b0;
            unlockArmed <= 1'b0;
        end
    end

    // One-way mode cannot clear, so a stuck lock needs a reset to lift
    wire lockCanSet = unlockArmed && lockReq;
    wire lockCanClear = unlockArmed && !lockReq && !pin_lock_one_way;
    always_ff @(posedge core_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            pin_select_lock <= 1'b0;
        end else if (wrLock && lockCanSet) begin
            pin_select_lock <= 1'b1;
        end else if (wrLock && lockCanClear) begin
            pin_select_lock <= 1'b0;
        end
    end

    generate
        for (genvar i = 0; i < MAP_REGS; i++) begin : g_map
            always_ff @(posedge core_clk or negedge rstSync2) begin
                if (!rstSync2) begin
                    mapReg[i] <= MAP_RESET;
                end else if (mapWrite && mapIdx == 6'(i)) begin
                    mapReg[i] <= pwdata[7:0];
                end
            end
            assign ppsMap[i*8 +: 8] = mapReg[i];
        end
    endgenerate

    // Checks
    property p_sw_fsm;
        @(posedge core_clk) disable iff (!rstSync2)
        (captured && csField == CS_SW_FSM) |=> (clkSwitchEn && failSafeMonEn);
    endproperty
    a_sw_fsm: assert property (p_sw_fsm) else $error("code 00 must enable both");

    property p_sw_only;
        @(posedge core_clk) disable iff (!rstSync2)
        (captured && csField == CS_SW_ONLY) |=> (clkSwitchEn && !failSafeMonEn);
    endproperty
    a_sw_only: assert property (p_sw_only) else $error("code 01 monitor must be off");

    property p_clkout;
        @(posedge core_clk) disable iff (!rstSync2)
        (captured && clkOutSel) [*2] |=> (oscOutPinOe && oscOutPinOut != $past(oscOutPinOut));
    endproperty
    a_clkout: assert property (p_clkout) else $error("output pin not toggling at half rate");

    property p_one_way_hold;
        @(posedge core_clk) disable iff (!rstSync2)
        (pin_lock_one_way && pin_select_lock) |=> pin_select_lock;
    endproperty
    a_one_way_hold: assert property (p_one_way_hold) else $error("one-way lock cleared");

    property p_set_needs_unlock;
        @(posedge core_clk) disable iff (!rstSync2)
        $rose(pin_select_lock) |-> ($past(unlockArmed) && $past(wrLock));
    endproperty
    a_set_needs_unlock: assert property (p_set_needs_unlock) else $error("lock set without unlock");

    property p_map_frozen;
        @(posedge core_clk) disable iff (!rstSync2)
        $past(pin_select_lock) |-> (ppsMap == $past(ppsMap));
    endproperty
    a_map_frozen: assert property (p_map_frozen) else $error("mapping changed while locked");

    property p_free_clear;
        @(posedge core_clk) disable iff (!rstSync2)
        (!pin_lock_one_way && pin_select_lock && wrLock && unlockArmed && !lockReq)
            |=> !pin_select_lock ##1 !unlockArmed;
    endproperty
    a_free_clear: assert property (p_free_clear) else $error("lock not cleared");

    property p_osc_off;
        @(posedge core_clk) disable iff (!rstSync2)
        (captured && modeOff) |=> !primaryOscEn;
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator on in mode 11");

    property p_mode_decode;
        @(posedge core_clk) disable iff (!rstSync2)
        captured |=> ((oscModeHs == ($past(primary_osc_mode) == OCL_XTAL_HS))
            && (oscModeXt == ($past(primary_osc_mode) == OCL_XTAL_STD))
            && (oscModeEc == ($past(primary_osc_mode) == OCL_EXT_CLK)));
    endproperty
    a_mode_decode: assert property (p_mode_decode) else $error("mode decode wrong");

    property p_xtal_pin;
        @(posedge core_clk) disable iff (!rstSync2)
        (captured && modeXtalAny) |=> (crystalDriverOwnsPin && !oscOutPinOe && !oscOutPinOut);
    endproperty
    a_xtal_pin: assert property (p_xtal_pin) else $error("crystal pin driven as clock");

    property p_quiet_before_capture;
        @(posedge core_clk) disable iff (!rstSync2)
        !captured |=> (!oscOutPinOe && !primaryOscEn && !clkSwitchEn && !crystalDriverOwnsPin);
    endproperty
    a_quiet_before_capture: assert property (p_quiet_before_capture) else $error("decode before capture");

    property p_clkout_off;
        @(posedge core_clk) disable iff (!rstSync2)
        (captured && !outFnBit) |=> (!oscOutPinOe && !oscOutPinOut);
    endproperty
    a_clkout_off: assert property (p_clkout_off) else $error("output pin driven with bit 5 clear");

    property p_osc_on;
        @(posedge core_clk) disable iff (!rstSync2)
        (captured && !modeOff) |=> primaryOscEn;
    endproperty
    a_osc_on: assert property (p_osc_on) else $error("oscillator off in an active mode");

    property p_cfg_static;
        @(posedge core_clk) disable iff (!rstSync2)
        captured |=> $stable(cfgWord);
    endproperty
    a_cfg_static: assert property (p_cfg_static) else $error("configuration changed after capture");

    property p_lock_stable;
        @(posedge core_clk) disable iff (!rstSync2)
        !wrLock |=> $stable(pin_select_lock);
    endproperty
    a_lock_stable: assert property (p_lock_stable) else $error("lock moved without a lock write");

    property p_armed_needs_key;
        @(posedge core_clk) disable iff (!rstSync2)
        $rose(unlockArmed) |-> ($past(wrUnlock) && ($past(pwdata[7:0]) == UNLOCK_KEY2));
    endproperty
    a_armed_needs_key: assert property (p_armed_needs_key) else $error("armed without second key");

    property p_open_map_write;
        @(posedge core_clk) disable iff (!rstSync2)
        (wrStrobe && paddr == ADDR_MAP_BASE && !pin_select_lock)
            |=> (ppsMap[7:0] == $past(pwdata[7:0]));
    endproperty
    a_open_map_write: assert property (p_open_map_write) else $error("open map write lost");

    c_lock_set: cover property (@(posedge core_clk) disable iff (!rstSync2)
        $rose(pin_select_lock));
    c_lock_clear: cover property (@(posedge core_clk) disable iff (!rstSync2)
        $fell(pin_select_lock));
    c_map_blocked: cover property (@(posedge core_clk) disable iff (!rstSync2)
        wrStrobe && isMap && pin_select_lock);
    c_clkout: cover property (@(posedge core_clk) disable iff (!rstSync2)
        oscOutPinOe);
endmodule

/* dv/ocl_config_decode_tb_top.sv */
// Self-checking bench for the configuration decoder, pin-select lock and mapping registers
`timescale 1ns/1ps
module ocl_config_decode_tb_top;
    import ocl_pkg::*;
    logic core_clk;
    logic resetn;
    logic [CFG_W-1:0] cfgWord;
    logic psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, a, b, oe;
    logic clkSwitchEn, failSafeMonEn, primaryOscEn, oscModeHs, oscModeXt, oscModeEc;
    logic crystalDriverOwnsPin, oscOutPinOut, oscOutPinOe, pin_select_lock;
    logic [63:0] ppsMap;
    logic [1:0] m, cs;
    int errors, checks_done;

    ocl_config_decode #(.MAP_REGS(8)) dut (
        .core_clk(core_clk), .resetn(resetn), .config_word_two(cfgWord),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clkSwitchEn(clkSwitchEn), .failSafeMonEn(failSafeMonEn), .primaryOscEn(primaryOscEn),
        .oscModeHs(oscModeHs), .oscModeXt(oscModeXt), .oscModeEc(oscModeEc),
        .crystalDriverOwnsPin(crystalDriverOwnsPin), .oscOutPinOut(oscOutPinOut),
        .oscOutPinOe(oscOutPinOe), .pin_select_lock(pin_select_lock), .ppsMap(ppsMap)
    );

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Holds the request until pready is seen high; a hang is left to the watchdog
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic unlock();
        apb(1'b1, ADDR_UNLOCK, {24'h000000, UNLOCK_KEY1});
        apb(1'b1, ADDR_UNLOCK, {24'h000000, UNLOCK_KEY2});
    endtask

    // Port is sampled half a cycle after the write edge so the update has landed
    task automatic chkLock(input logic exp);
        @(negedge core_clk);
        check("pin_select_lock", {31'h0, exp}, {31'h0, pin_select_lock});
    endtask

    // Word is static, so a new value needs a fresh reset to be captured
    task automatic restart(input logic [CFG_W-1:0] w);
        @(posedge core_clk);
        cfgWord <= w;
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge core_clk);
        // Outputs are looked at between edges, never in the launching time step
        @(negedge core_clk);
    endtask

    function automatic logic [CFG_W-1:0] mkWord(input logic [1:0] c, input logic fn,
                                                input logic ow, input logic [1:0] md);
        return {16'hFFFF, c, fn, ow, 2'b11, md};
    endfunction

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial begin
        #2000000;
        errors++;
        $display("unexpected timeout: expected end of tests, seen none");
        conclude();
    end

    initial begin
        resetn = 1'b0;
        cfgWord = CFG_ERASED;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        for (int i = 0; i < 16; i++) begin
            m = i[1:0];
            cs = i[3:2];
            oe = (m == 2'h3 || m == 2'h0) && (i[0] ^ i[3]);
            restart(mkWord(cs, i[0] ^ i[3], 1'b0, m));
            check("clkSwitchEn", {31'h0, cs < 2'h2}, {31'h0, clkSwitchEn});
            check("failSafeMonEn", {31'h0, cs == 2'h0}, {31'h0, failSafeMonEn});
            check("primaryOscEn", {31'h0, m != 2'h3}, {31'h0, primaryOscEn});
            check("oscModes", {29'h0, m == 2'h2, m == 2'h1, m == 2'h0},
                  {29'h0, oscModeHs, oscModeXt, oscModeEc});
            check("crystalDriverOwnsPin", {31'h0, m == 2'h1 || m == 2'h2},
                  {31'h0, crystalDriverOwnsPin});
            check("oscOutPinOe", {31'h0, oe}, {31'h0, oscOutPinOe});
            a = oscOutPinOut;
            @(negedge core_clk);
            b = oscOutPinOut;
            // Half-rate clock: two neighbouring samples differ, and both are 0 when off
            check("oscOutPinOut", {30'h0, oe, oe}, {30'h0, a | b, a ^ b});
            apb(1'b0, ADDR_CFG, 32'h0);
            check("cfgWord", {8'h00, mkWord(cs, i[0] ^ i[3], 1'b0, m)}, rd);
        end
        restart(mkWord(2'h0, 1'b0, 1'b1, 2'h0));
        apb(1'b1, ADDR_MAP_BASE, 32'h0000005A);
        apb(1'b1, ADDR_LOCK, 32'h00000001);
        chkLock(1'b0);
        unlock();
        apb(1'b1, ADDR_LOCK, 32'h00000001);
        chkLock(1'b1);
        apb(1'b1, ADDR_MAP_BASE + 8'h04, 32'h00000033);
        apb(1'b1, ADDR_MAP_BASE, 32'h000000C3);
        apb(1'b0, ADDR_MAP_BASE + 8'h04, 32'h0);
        check("map1 read", 32'h00000000, rd);
        apb(1'b0, ADDR_MAP_BASE, 32'h0);
        check("map0 read", 32'h0000005A, rd);
        check("ppsMap", 32'h0000005A, ppsMap[31:0]);
        unlock();
        apb(1'b1, ADDR_LOCK, 32'h00000000);
        chkLock(1'b1);
        restart(mkWord(2'h1, 1'b0, 1'b0, 2'h0));
        for (int k = 0; k < 2; k++) begin
            unlock();
            apb(1'b1, ADDR_LOCK, 32'h00000001);
            chkLock(1'b1);
            unlock();
            apb(1'b1, ADDR_LOCK, 32'h00000000);
            chkLock(1'b0);
        end
        // A write between the two keys must break the sequence
        apb(1'b1, ADDR_UNLOCK, {24'h000000, UNLOCK_KEY1});
        apb(1'b1, ADDR_MAP_BASE + 8'h1C, 32'h00000011);
        apb(1'b1, ADDR_UNLOCK, {24'h000000, UNLOCK_KEY2});
        apb(1'b1, ADDR_LOCK, 32'h00000001);
        chkLock(1'b0);
        check("ppsMap top", 32'h00000011, {24'h0, ppsMap[63:56]});
        apb(1'b0, 8'h30, 32'h0);
        check("unmapped err", 32'h00000001, {31'h0, err});
        check("unmapped read", 32'h00000000, rd);
        apb(1'b1, ADDR_CFG, 32'h00000000);
        apb(1'b0, ADDR_CFG, 32'h0);
        check("cfgWord after write", {8'h00, mkWord(2'h1, 1'b0, 1'b0, 2'h0)}, rd);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("status", 32'h0000020B, rd);
        conclude();
    end
endmodule
